/* design/otseq_cfg.svh */
// Timing constants for the over-temperature sequencer
`ifndef OTSEQ_CFG_SVH
`define OTSEQ_CFG_SVH
`define OTSEQ_CLK_MHZ       200
`define OTSEQ_INTERVAL_S    60
`define OTSEQ_INTERVAL_CYC  (36'(`OTSEQ_INTERVAL_S) * 36'(`OTSEQ_CLK_MHZ) \
                             * 36'd1000000)
`define OTSEQ_NUM_MODULES   20
`define OTSEQ_RST_PULSE_CYC 16
`endif

/* design/otseq_pkg.sv */
// Types for the over-temperature sequencer
`default_nettype none
package otseq_pkg;
    typedef enum logic [3:0] {
        OTSEQ_NORMAL  = 4'b0001,
        OTSEQ_WATCH   = 4'b0010,
        OTSEQ_YELLOW  = 4'b0100,
        OTSEQ_RED     = 4'b1000
    } otseq_state_e;

    typedef enum logic [1:0] {
        OTSEQ_LED_GREEN  = 2'h0,
        OTSEQ_LED_YELLOW = 2'h1,
        OTSEQ_LED_RED    = 2'h2
    } otseq_led_e;

    typedef struct packed {
        logic suspend_ops;
        logic suspend_sync_start;
        logic reserve_all;
        logic stop_traffic;
        logic functions_off;
    } otseq_ctrl_s;
endpackage
`default_nettype wire

/* design/otseq_top.sv */
// Over-temperature supervision sequencer
// Notes on behaviour
// - No over-temperature: indicator green
// - First sense: stay green, start one-minute watch
// - Still hot after minute: yellow, suspend ops
// - Yellow also reserves modules, stops traffic
// - Yellow runs a second one-minute watch
// - Still hot: reset modules in use, red
// - Host reset reinitialises, monitoring stays active
// - Still hot after reset: sequence restarts
// - Cool again: back to green, usable
// - Login while hot raises warning pulse
// - Red keeps chassis functions disabled
`include "otseq_cfg.svh"
`default_nettype none
module otseq_top
    import otseq_pkg::*;
#(
    parameter logic [35:0] INTERVAL_CYC = `OTSEQ_INTERVAL_CYC
) (
    input  wire logic                          mclk_i,
    input  wire logic                          rst_i,
    input  wire logic                          over_temp_i,
    input  wire logic                          host_reset_i,
    input  wire logic                          login_i,
    input  wire logic [`OTSEQ_NUM_MODULES-1:0] module_in_use_i,
    output var  otseq_led_e                    temp_led_o,
    output var  otseq_ctrl_s                   ctrl_o,
    output logic [`OTSEQ_NUM_MODULES-1:0]      module_reset_o,
    output logic                               chassis_init_o,
    output logic                               login_warn_o
);
    // Sizes and terminal counts
    localparam int unsigned NM         = `OTSEQ_NUM_MODULES;
    localparam logic [7:0]  RST_LEN    = 8'(`OTSEQ_RST_PULSE_CYC);
    localparam logic [35:0] TIMER_LAST = INTERVAL_CYC - 36'h1;

    // Green stages: all module controls released
    localparam otseq_ctrl_s CTRL_OFF = '{
        suspend_ops:        1'b0,
        suspend_sync_start: 1'b0,
        reserve_all:        1'b0,
        stop_traffic:       1'b0,
        functions_off:      1'b0
    };
    // Yellow: suspend, reserve and stop traffic
    localparam otseq_ctrl_s CTRL_YELLOW = '{
        suspend_ops:        1'b1,
        suspend_sync_start: 1'b1,
        reserve_all:        1'b1,
        stop_traffic:       1'b1,
        functions_off:      1'b0
    };
    // Red: chassis functions disabled as well
    localparam otseq_ctrl_s CTRL_RED = '{
        suspend_ops:        1'b1,
        suspend_sync_start: 1'b1,
        reserve_all:        1'b1,
        stop_traffic:       1'b1,
        functions_off:      1'b1
    };

    // Synchronised inputs and edge history
    logic            ot_meta_reg;
    logic            ot_sync_reg;
    logic            hr_meta_reg;
    logic            hr_sync_reg;
    logic            hr_prev_reg;
    logic            li_meta_reg;
    logic            li_sync_reg;
    logic            li_prev_reg;

    // Sequence state and interval timer
    otseq_state_e    state_reg;
    otseq_state_e    state_seq;
    otseq_state_e    state_next;
    logic [35:0]     timer_reg;
    logic            timer_done;
    logic            timer_clr;
    logic            timer_run;

    // Event strobes
    logic            host_rst_pulse;
    logic            login_rise;
    logic            enter_red;

    // Output next values and counters
    otseq_led_e      led_next;
    otseq_ctrl_s     ctrl_next;
    logic [NM-1:0]   mod_rst_next;
    logic [7:0]      init_cnt_reg;

    // Over-temperature level synchroniser
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ot_meta_reg <= 1'b0;
            ot_sync_reg <= 1'b0;
        end else begin
            ot_meta_reg <= over_temp_i;
            ot_sync_reg <= ot_meta_reg;
        end
    end

    // Host reset synchroniser and edge history
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            hr_meta_reg <= 1'b0;
            hr_sync_reg <= 1'b0;
            hr_prev_reg <= 1'b0;
        end else begin
            hr_meta_reg <= host_reset_i;
            hr_sync_reg <= hr_meta_reg;
            hr_prev_reg <= hr_sync_reg;
        end
    end

    // Login synchroniser and edge history
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            li_meta_reg <= 1'b0;
            li_sync_reg <= 1'b0;
            li_prev_reg <= 1'b0;
        end else begin
            li_meta_reg <= login_i;
            li_sync_reg <= li_meta_reg;
            li_prev_reg <= li_sync_reg;
        end
    end

    // Host reset accepted in every state
    assign host_rst_pulse = hr_sync_reg & ~hr_prev_reg;
    assign login_rise     = li_sync_reg & ~li_prev_reg;
    assign timer_done     = (timer_reg == TIMER_LAST);
    assign enter_red      = (state_reg == OTSEQ_YELLOW)
                            && (state_next == OTSEQ_RED);

    // Escalation path
    always_comb begin
        state_seq = state_reg;
        unique case (state_reg)
            OTSEQ_NORMAL: begin
                if (ot_sync_reg) begin
                    state_seq = OTSEQ_WATCH;
                end
            end
            OTSEQ_WATCH: begin
                if (!ot_sync_reg) begin
                    state_seq = OTSEQ_NORMAL;
                end else if (timer_done) begin
                    state_seq = OTSEQ_YELLOW;
                end
            end
            OTSEQ_YELLOW: begin
                if (!ot_sync_reg) begin
                    state_seq = OTSEQ_NORMAL;
                end else if (timer_done) begin
                    state_seq = OTSEQ_RED;
                end
            end
            OTSEQ_RED: begin
                if (!ot_sync_reg) begin
                    state_seq = OTSEQ_NORMAL;
                end
            end
            default: state_seq = OTSEQ_NORMAL;
        endcase
    end

    // Host reset overrides the escalation path
    always_comb begin
        state_next = state_seq;
        if (host_rst_pulse) begin
            // Monitoring continues; escalation restarts while hot
            state_next = ot_sync_reg ? OTSEQ_WATCH
                                     : OTSEQ_NORMAL;
        end
    end

    // Sequence state register
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_reg <= OTSEQ_NORMAL;
        end else begin
            state_reg <= state_next;
        end
    end

    // Interval timer control
    always_comb begin
        timer_clr = (state_next != state_reg) || host_rst_pulse;
        timer_run = (state_reg == OTSEQ_WATCH)
                    || (state_reg == OTSEQ_YELLOW);
    end

    // Interval timer, restarted on every state change
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            timer_reg <= 36'h0;
        end else if (timer_clr) begin
            timer_reg <= 36'h0;
        end else if (timer_run) begin
            timer_reg <= timer_reg + 36'h1;
        end
    end

    // Indicator and control decode of the next state
    always_comb begin
        led_next  = OTSEQ_LED_GREEN;
        ctrl_next = CTRL_OFF;
        unique case (state_next)
            OTSEQ_NORMAL: begin
                led_next  = OTSEQ_LED_GREEN;
                ctrl_next = CTRL_OFF;
            end
            OTSEQ_WATCH: begin
                led_next  = OTSEQ_LED_GREEN;
                ctrl_next = CTRL_OFF;
            end
            OTSEQ_YELLOW: begin
                led_next  = OTSEQ_LED_YELLOW;
                ctrl_next = CTRL_YELLOW;
            end
            OTSEQ_RED: begin
                led_next  = OTSEQ_LED_RED;
                ctrl_next = CTRL_RED;
            end
            default: begin
                led_next  = OTSEQ_LED_GREEN;
                ctrl_next = CTRL_OFF;
            end
        endcase
    end

    // Indicator register
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            temp_led_o <= OTSEQ_LED_GREEN;
        end else begin
            temp_led_o <= led_next;
        end
    end

    // Module control register
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ctrl_o <= CTRL_OFF;
        end else begin
            ctrl_o <= ctrl_next;
        end
    end

    // Reset of modules in use on entering red
    always_comb begin
        mod_rst_next = {NM{1'b0}};
        if (enter_red) begin
            mod_rst_next = module_in_use_i;
        end
    end

    // Module reset pulse register
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            module_reset_o <= {NM{1'b0}};
        end else begin
            module_reset_o <= mod_rst_next;
        end
    end

    // Chassis initialisation length counter
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            init_cnt_reg <= 8'h0;
        end else if (host_rst_pulse) begin
            // A new host reset restarts the strobe
            init_cnt_reg <= RST_LEN - 8'h1;
        end else if (init_cnt_reg != 8'h0) begin
            init_cnt_reg <= init_cnt_reg - 8'h1;
        end
    end

    // Chassis initialisation strobe
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            chassis_init_o <= 1'b0;
        end else begin
            chassis_init_o <= host_rst_pulse
                              | (init_cnt_reg != 8'h0);
        end
    end

    // Login warning pulse while over temperature
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            login_warn_o <= 1'b0;
        end else begin
            login_warn_o <= login_rise & ot_sync_reg;
        end
    end
endmodule
`default_nettype wire

/* verification/otseq_monitor.sv */
// Port assertions for the over-temperature sequencer
`default_nettype none
module otseq_monitor
    import otseq_pkg::*;
#(
    parameter logic [35:0] INTERVAL_CYC = 36'd20
) (
    input wire logic        mclk_i,
    input wire logic        rst_i,
    input wire logic        over_temp_i,
    input wire logic [19:0] module_in_use_i,
    input var  otseq_led_e  temp_led_o,
    input var  otseq_ctrl_s ctrl_o,
    input wire logic [19:0] module_reset_o,
    input wire logic        chassis_init_o,
    input wire logic        login_warn_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic [35:0] yel_cnt_reg;
    // Cycles the indicator has shown yellow
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            yel_cnt_reg <= 36'h0;
        end else if (temp_led_o == OTSEQ_LED_YELLOW) begin
            yel_cnt_reg <= yel_cnt_reg + 36'h1;
        end else begin
            yel_cnt_reg <= 36'h0;
        end
    end
    a_yellow_length: assert property ($rose(temp_led_o == OTSEQ_LED_RED)
        |-> yel_cnt_reg == INTERVAL_CYC) else $error("yellow stage length wrong");
    a_green_ctrl_off: assert property (temp_led_o == OTSEQ_LED_GREEN
        |-> ctrl_o == 5'h00) else $error("ctrl set while green");
    a_yellow_ctrl_on: assert property (temp_led_o == OTSEQ_LED_YELLOW
        |-> ctrl_o == 5'h1e) else $error("yellow ctrl wrong");
    a_red_ctrl_on: assert property (temp_led_o == OTSEQ_LED_RED
        |-> ctrl_o == 5'h1f) else $error("red ctrl wrong");
    a_red_from_yellow: assert property (temp_led_o == OTSEQ_LED_RED
        |-> $past(temp_led_o) != OTSEQ_LED_GREEN) else $error("red too early");
    a_reset_in_use: assert property ($rose(temp_led_o == OTSEQ_LED_RED)
        |-> module_reset_o == $past(module_in_use_i)) else $error("bad resets");
    a_reset_one_cycle: assert property (module_reset_o != 20'h00000
        |-> temp_led_o == OTSEQ_LED_RED ##1 module_reset_o == 20'h00000)
        else $error("module reset pulse wrong");
    a_cool_green: assert property (!over_temp_i [*3]
        |=> temp_led_o == OTSEQ_LED_GREEN) else $error("not green when cool");
    a_init_length: assert property ($rose(chassis_init_o)
        |-> chassis_init_o [*8] ##1 chassis_init_o [*8] ##1 !chassis_init_o)
        else $error("init strobe length wrong");
    a_warn_one_cycle: assert property (login_warn_o
        |=> !login_warn_o) else $error("warn pulse too long");
endmodule
bind otseq_top otseq_monitor #(.INTERVAL_CYC(INTERVAL_CYC)) chk_u (
    .mclk_i, .rst_i, .over_temp_i, .module_in_use_i, .temp_led_o,
    .ctrl_o, .module_reset_o, .chassis_init_o, .login_warn_o);
`default_nettype wire

/* verification/otseq_partner.sv */
// Controller and test module model facing the sequencer
`default_nettype none
module otseq_partner (
    input  wire logic        mclk_i,
    input  wire logic [19:0] use_i,
    input  wire logic        reset_req_i,
    input  wire logic [19:0] module_reset_i,
    output logic [19:0]      module_in_use_o,
    output logic             host_reset_o,
    output int               resets_seen_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [19:0] use_q = 20'h00000;
    logic        req_q = 1'b0;
    initial begin
        module_in_use_o = 20'h00000;
        host_reset_o = 1'b0;
        resets_seen_o = 0;
    end
    always @(posedge mclk_i) begin
        use_q <= use_i;
        req_q <= reset_req_i;
        resets_seen_o <= resets_seen_o + $countones(module_reset_i);
    end
    always @(negedge mclk_i) begin
        module_in_use_o <= use_q;
        host_reset_o <= req_q;
    end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the over-temperature sequencer
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
    error_cnt++; $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module tb_top
    import otseq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int IC = 20;
    logic        mclk_i = 1'b0, rst_i = 1'b1, over_temp_i = 1'b0;
    logic        login_i = 1'b0, req = 1'b0, host_rst, init, warn;
    logic [19:0] use_r = 20'h00000, in_use, mres;
    otseq_led_e  led;
    otseq_ctrl_s ctrl;
    int          error_cnt = 0, comparisons = 0, seen, w;
    int          d[3] = '{5, IC + 5, 2 * IC + 5};
    otseq_top #(.INTERVAL_CYC(36'(IC))) dut_u (.mclk_i, .rst_i, .over_temp_i,
        .host_reset_i(host_rst), .login_i, .module_in_use_i(in_use),
        .temp_led_o(led), .ctrl_o(ctrl), .module_reset_o(mres),
        .chassis_init_o(init), .login_warn_o(warn));
    otseq_partner pm_u (.mclk_i, .use_i(use_r), .reset_req_i(req),
        .module_reset_i(mres), .module_in_use_o(in_use),
        .host_reset_o(host_rst), .resets_seen_o(seen));
    initial forever #2.5 mclk_i = ~mclk_i;
    task automatic cyc(int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic stop_test();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wait_for(int sel);
        int n;
        for (n = 0; n < 12 && (sel ? warn : init) !== 1'b1; n++) cyc(1);
        if (n == 12) begin
            error_cnt++;
            stop_test();
        end
    endtask
    function automatic otseq_led_e exp_led(int k, int h);
        if (k >= h + 3 || k < 3 + IC) return OTSEQ_LED_GREEN;
        return (k >= 3 + 2 * IC) ? OTSEQ_LED_RED : OTSEQ_LED_YELLOW;
    endfunction
    function automatic otseq_ctrl_s exp_ctrl(otseq_led_e l);
        if (l == OTSEQ_LED_GREEN) return 5'h00;
        return (l == OTSEQ_LED_RED) ? 5'h1f : 5'h1e;
    endfunction
    // Hot for h edges, then cool; led and ctrl checked per cycle, module resets on the cycle red is entered
    task automatic run(int h);
        int s0, n;
        s0 = seen;
        n = 0;
        use_r = 20'($urandom);
        over_temp_i = 1'b1;
        for (int k = 1; k <= h + 6; k++) begin
            cyc(1);
            `CHK("led", exp_led(k, h), led)
            `CHK("ctrl", exp_ctrl(exp_led(k, h)), ctrl)
            if (exp_led(k, h) == OTSEQ_LED_RED && exp_led(k - 1, h)
                    == OTSEQ_LED_YELLOW) begin
                `CHK("module reset", use_r, mres)
                n += $countones(use_r);
            end
            if (k == h) over_temp_i = 1'b0;
        end
        `CHK("partner reset count", n, seen - s0)
        $display("run hot %0d done, errors %0d", h, error_cnt);
    endtask
    initial begin
        void'($urandom(85));
        cyc(4);
        rst_i = 1'b0;
        cyc(3);
        `CHK("led after reset", OTSEQ_LED_GREEN, led)
        foreach (d[i]) run(d[i] - 3);
        run(IC);
        run(IC + 1);
        run(3 * IC);
        repeat (4) run($urandom_range(1, 3 * IC));
        foreach (d[i]) begin
            over_temp_i = 1'b1;
            cyc(d[i]);
            req = 1'b1;
            cyc(2);
            req = 1'b0;
            wait_for(0);
            `CHK("led host reset", OTSEQ_LED_GREEN, led)
            cyc(IC - 1);
            `CHK("led before restart", OTSEQ_LED_GREEN, led)
            cyc(1);
            `CHK("led restart", OTSEQ_LED_YELLOW, led)
            over_temp_i = 1'b0;
            cyc(20);
            `CHK("led cooled", OTSEQ_LED_GREEN, led)
        end
        $display("host reset test done, errors %0d", error_cnt);
        over_temp_i = 1'b1;
        cyc(5);
        login_i = 1'b1;
        wait_for(1);
        `CHK("warn while hot", 1'b1, warn)
        login_i = 1'b0;
        over_temp_i = 1'b0;
        cyc(6);
        login_i = 1'b1;
        w = 0;
        repeat (8) begin
            cyc(1);
            w += (warn === 1'b1);
        end
        `CHK("warn while cool", 0, w)
        login_i = 1'b0;
        $display("login test done, errors %0d", error_cnt);
        stop_test();
    end
endmodule
`default_nettype wire
